// *** hw/dpft_transition.sv ***
module dpft_transition
	import dpft_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEF,
	parameter int RELOCK_CYCLES  = RELOCK_CYCLES_DEF
) (
	// Clock and reset
	input  wire logic           CLK,
	input  wire logic           SYS_RST,
	// Configuration levels
	input  wire logic           REF_MUX_TRANSITION,
	input  wire logic           RESET_OPTION,
	input  wire logic           SPLIT_SUPPLY,
	// Pins
	input  wire logic           REGISTER_SELECT_LO,
	input  wire logic           REGISTER_SELECT_HI,
	input  wire logic           ANALOG_SUPPLY_TRIP,
	// Frequency register writes
	input  wire dpft_write_type WRITE,
	// Clock outputs
	output dpft_clock_type      VIDEO_CLOCK_OUT,
	output dpft_clock_type      MEMORY_CLOCK_OUT,
	// Status
	output logic                VIDEO_BUSY,
	output logic                MEMORY_BUSY,
	output logic                PLL_LOCKED
);

	typedef struct packed {
		logic [1:0]               sel_meta;
		logic [1:0]               sel_sync;
		logic                     trip_meta;
		logic                     trip_sync;
		logic                     trip_prev;
		logic [COUNT_W-1:0]       relock_count;
		logic                     locked;
		logic                     memory_first;
		dpft_setting_type [3:0]   video_bank;
		dpft_setting_type [1:0]   memory_bank;
		dpft_chan_type    [1:0]   chan;
	} dpft_state_type;

	localparam logic [COUNT_W-1:0] TIMEOUT_LOAD = COUNT_W'(TIMEOUT_CYCLES);
	localparam logic [COUNT_W-1:0] RELOCK_LOAD  = COUNT_W'(RELOCK_CYCLES);
	localparam logic [COUNT_W-1:0] HOLD_LOAD    = COUNT_W'(MUX_HOLD_CYCLES);

	dpft_state_type cur;
	dpft_state_type next_state;

	function automatic dpft_setting_type clamp_setting(
		input dpft_setting_type  s,
		input logic [FREQ_W-1:0] lo,
		input logic [FREQ_W-1:0] hi
	);
		dpft_setting_type r;
		r = s;
		if (s.vco_khz > hi) begin
			r.vco_khz = hi;
		end else if (s.vco_khz < lo) begin
			r.vco_khz = lo;
		end
		return r;
	endfunction : clamp_setting

	always_comb begin
		logic [1:0]        sel;
		logic [1:0]        idx [2];
		logic              trig [2];
		logic              sel_change [2];
		logic [FREQ_W-1:0] lim_lo;
		logic [FREQ_W-1:0] lim_hi;
		logic [FREQ_W-1:0] diff;
		dpft_setting_type  want;
		sel        = 2'h0;
		idx        = '{2'h0, 2'h0};
		trig       = '{1'b0, 1'b0};
		sel_change = '{1'b0, 1'b0};
		lim_lo     = '0;
		lim_hi     = '0;
		diff       = '0;
		want       = '0;
		next_state = cur;

		// Pin synchronisers
		next_state.sel_meta  = {REGISTER_SELECT_HI, REGISTER_SELECT_LO};
		next_state.sel_sync  = cur.sel_meta;
		next_state.trip_meta = ANALOG_SUPPLY_TRIP;
		next_state.trip_sync = cur.trip_meta;
		next_state.trip_prev = cur.trip_sync;
		sel = cur.sel_sync;

		// Register writes
		if (WRITE.valid) begin
			if (WRITE.to_memory) begin
				next_state.memory_bank[WRITE.index[0]] = WRITE.data;
			end else begin
				next_state.video_bank[WRITE.index] = WRITE.data;
			end
		end

		idx[0] = sel;
		idx[1] = (RESET_OPTION && sel == SEL_SWAP_CODE) ? 2'h1 : 2'h0;
		for (int i = 0; i < 2; i++) begin
			sel_change[i] = idx[i] != cur.chan[i].seen_idx;
			trig[i] = sel_change[i] || (WRITE.valid && WRITE.to_memory == (i == 1)
				&& (i == 1 ? WRITE.index[0] == idx[1][0] : WRITE.index == idx[0]));
			next_state.chan[i].seen_idx = idx[i];
		end

		if (RESET_OPTION && sel_change[1] && sel_change[0]) begin
			next_state.memory_first = 1'b1;
		end else if (cur.memory_first && cur.chan[1].phase == PH_IDLE && !cur.chan[1].pending) begin
			next_state.memory_first = 1'b0;
		end

		for (int i = 0; i < 2; i++) begin
			if (i == 0) begin
				lim_lo = VIDEO_MIN_KHZ;
				lim_hi = SPLIT_SUPPLY ? VIDEO_MAX_LOW_KHZ : VIDEO_MAX_FULL_KHZ;
				want   = clamp_setting(cur.video_bank[idx[0]], lim_lo, lim_hi);
			end else begin
				lim_lo = MEMORY_MIN_KHZ;
				lim_hi = SPLIT_SUPPLY ? MEMORY_MAX_LOW_KHZ : MEMORY_MAX_FULL_KHZ;
				want   = clamp_setting(cur.memory_bank[idx[1][0]], lim_lo, lim_hi);
			end
			case (cur.chan[i].phase)
				PH_IDLE: begin
					if (cur.chan[i].pending && !(i == 0 && cur.memory_first)) begin
						next_state.chan[i].pending = 1'b0;
						next_state.chan[i].target  = want;
						if (REF_MUX_TRANSITION) begin
							next_state.chan[i].phase = PH_MUX_HOLD;
							next_state.chan[i].count = HOLD_LOAD;
						end else begin
							next_state.chan[i].phase = PH_GLIDE;
							if (want.post_div > cur.chan[i].clk.post_div) begin
								next_state.chan[i].clk.post_div = want.post_div;
							end
						end
					end
				end
				PH_GLIDE: begin
					if (cur.chan[i].clk.vco_khz < cur.chan[i].target.vco_khz) begin
						diff = cur.chan[i].target.vco_khz - cur.chan[i].clk.vco_khz;
						next_state.chan[i].clk.vco_khz = cur.chan[i].clk.vco_khz
							+ ((diff < GLIDE_STEP_KHZ) ? diff : GLIDE_STEP_KHZ);
					end else if (cur.chan[i].clk.vco_khz > cur.chan[i].target.vco_khz) begin
						diff = cur.chan[i].clk.vco_khz - cur.chan[i].target.vco_khz;
						next_state.chan[i].clk.vco_khz = cur.chan[i].clk.vco_khz
							- ((diff < GLIDE_STEP_KHZ) ? diff : GLIDE_STEP_KHZ);
					end else begin
						next_state.chan[i].clk.post_div = cur.chan[i].target.post_div;
						next_state.chan[i].phase        = PH_IDLE;
					end
				end
				PH_MUX_HOLD: begin
					if (cur.chan[i].count <= COUNT_W'(1)) begin
						next_state.chan[i].clk.source   = SRC_SUBST;
						next_state.chan[i].clk.vco_khz  = cur.chan[i].target.vco_khz;
						next_state.chan[i].clk.post_div = cur.chan[i].target.post_div;
						next_state.chan[i].count        = TIMEOUT_LOAD;
						next_state.chan[i].phase        = PH_MUX_SETTLE;
					end else begin
						next_state.chan[i].count = cur.chan[i].count - COUNT_W'(1);
					end
				end
				PH_MUX_SETTLE: begin
					if (cur.chan[i].count <= COUNT_W'(1)) begin
						next_state.chan[i].clk.source = SRC_VCO;
						next_state.chan[i].count      = '0;
						next_state.chan[i].phase      = PH_IDLE;
					end else begin
						next_state.chan[i].count = cur.chan[i].count - COUNT_W'(1);
					end
				end
				default: begin
					next_state.chan[i].phase = PH_IDLE;
				end
			endcase
			// Trigger wins over clear
			if (trig[i]) begin
				next_state.chan[i].pending = 1'b1;
			end
		end

		if (cur.trip_sync != cur.trip_prev) begin
			next_state.locked       = 1'b0;
			next_state.relock_count = RELOCK_LOAD;
		end else if (cur.relock_count != '0) begin
			next_state.relock_count = cur.relock_count - COUNT_W'(1);
			if (cur.relock_count == COUNT_W'(1)) begin
				next_state.locked = 1'b1;
			end
		end

		if (SYS_RST) begin
			next_state        = '0;
			next_state.locked = 1'b1;
			for (int k = 0; k < 4; k++) begin
				next_state.video_bank[k] = VIDEO_RESET_SETTING;
			end
			for (int k = 0; k < 2; k++) begin
				next_state.memory_bank[k] = MEMORY_RESET_SETTING;
			end
			next_state.chan[0].clk.post_div = VIDEO_RESET_SETTING.post_div;
			next_state.chan[0].clk.vco_khz  = VIDEO_RESET_SETTING.vco_khz;
			next_state.chan[0].target       = VIDEO_RESET_SETTING;
			next_state.chan[1].clk.post_div = MEMORY_RESET_SETTING.post_div;
			next_state.chan[1].clk.vco_khz  = MEMORY_RESET_SETTING.vco_khz;
			next_state.chan[1].target       = MEMORY_RESET_SETTING;
		end
	end

	always_ff @(posedge CLK) begin
		cur <= next_state;
	end

	assign VIDEO_CLOCK_OUT  = cur.chan[0].clk;
	assign MEMORY_CLOCK_OUT = cur.chan[1].clk;
	assign VIDEO_BUSY       = cur.chan[0].phase != PH_IDLE;
	assign MEMORY_BUSY      = cur.chan[1].phase != PH_IDLE;
	assign PLL_LOCKED       = cur.locked;

endmodule : dpft_transition

// *** include/dpft_pkg.sv ***
package dpft_pkg;

	// Timing
	localparam int CLK_PERIOD_NS       = 4;
	localparam int REF_PERIOD_NS       = 70;
	localparam int MUX_HOLD_NS         = REF_PERIOD_NS / 2;
	localparam int MUX_HOLD_CYCLES     = (MUX_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMEOUT_MS          = 5;
	localparam int TIMEOUT_CYCLES_DEF  = TIMEOUT_MS * (1000000 / CLK_PERIOD_NS);
	localparam int RELOCK_MS           = 4;
	localparam int RELOCK_CYCLES_DEF   = RELOCK_MS * (1000000 / CLK_PERIOD_NS);

	// Widths
	localparam int FREQ_W  = 18;
	localparam int COUNT_W = 21;

	// VCO limits in kHz
	localparam logic [FREQ_W-1:0] VIDEO_MIN_KHZ      = 18'h0c350;
	localparam logic [FREQ_W-1:0] VIDEO_MAX_FULL_KHZ = 18'h20f58;
	localparam logic [FREQ_W-1:0] VIDEO_MAX_LOW_KHZ  = 18'h186a0;
	localparam logic [FREQ_W-1:0] MEMORY_MIN_KHZ     = 18'h09c40;
	localparam logic [FREQ_W-1:0] MEMORY_MAX_FULL_KHZ = 18'h186a0;
	localparam logic [FREQ_W-1:0] MEMORY_MAX_LOW_KHZ = 18'h13880;

	// Glide rate in kHz per clock
	localparam logic [FREQ_W-1:0] GLIDE_STEP_KHZ = 18'h00010;

	// Select code that swaps the memory register when the reset option is on
	localparam logic [1:0] SEL_SWAP_CODE = 2'h3;

	typedef struct packed {
		logic [1:0]        post_div;
		logic [FREQ_W-1:0] vco_khz;
	} dpft_setting_type;

	localparam dpft_setting_type VIDEO_RESET_SETTING  = '{post_div: 2'h1, vco_khz: 18'h11170};
	localparam dpft_setting_type MEMORY_RESET_SETTING = '{post_div: 2'h0, vco_khz: 18'h0ea60};

	typedef enum logic [2:0] {
		PH_IDLE       = 3'b000,
		PH_GLIDE      = 3'b001,
		PH_MUX_HOLD   = 3'b010,
		PH_MUX_SETTLE = 3'b011
	} dpft_phase_type;

	typedef enum logic {
		SRC_VCO   = 1'b0,
		SRC_SUBST = 1'b1
	} dpft_source_type;

	typedef struct packed {
		dpft_source_type   source;
		logic [1:0]        post_div;
		logic [FREQ_W-1:0] vco_khz;
	} dpft_clock_type;

	typedef struct packed {
		logic             valid;
		logic             to_memory;
		logic [1:0]       index;
		dpft_setting_type data;
	} dpft_write_type;

	typedef struct packed {
		dpft_phase_type     phase;
		logic               pending;
		logic [1:0]         seen_idx;
		dpft_clock_type     clk;
		dpft_setting_type   target;
		logic [COUNT_W-1:0] count;
	} dpft_chan_type;

endpackage : dpft_pkg

// *** tb/dpft_consumer.sv ***
module dpft_consumer
	import dpft_pkg::*;
(
	// Clock and control
	input  wire logic                 clk,
	input  wire logic                 clear,
	// Clocks consumed, video in 0, memory in 1
	input  wire dpft_clock_type [1:0] clock_in,
	// Highest VCO-derived frequency seen
	output logic [1:0][FREQ_W-1:0]    peak
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (clear || (!clock_in[i].source && (clock_in[i].vco_khz >> clock_in[i].post_div) > peak[i])) begin
				peak[i] <= clock_in[i].vco_khz >> clock_in[i].post_div;
			end
		end
	end
endmodule : dpft_consumer

// *** tb/dpft_transition_properties.sv ***
module dpft_transition_properties
	import dpft_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = 20,
	parameter int RELOCK_CYCLES  = 30
) (
	// Clock and reset
	input wire logic           CLK,
	input wire logic           SYS_RST,
	// Levels
	input wire logic           REF_MUX_TRANSITION,
	input wire logic           RESET_OPTION,
	input wire logic           ANALOG_SUPPLY_TRIP,
	// Outputs
	input wire dpft_clock_type VIDEO_CLOCK_OUT,
	input wire dpft_clock_type MEMORY_CLOCK_OUT,
	input wire logic           VIDEO_BUSY,
	input wire logic           MEMORY_BUSY,
	input wire logic           PLL_LOCKED
);
	timeunit 1ns;
	timeprecision 1ps;
	wire dpft_clock_type v = VIDEO_CLOCK_OUT;
	wire dpft_clock_type m = MEMORY_CLOCK_OUT;
	logic        rd;
	logic [31:0] vsub;
	logic [31:0] lowc;
	always_ff @(posedge CLK) begin
		rd   <= SYS_RST;
		vsub <= (SYS_RST || !v.source) ? 32'h0 : vsub + 32'h1;
		lowc <= (SYS_RST || PLL_LOCKED) ? 32'h0 : lowc + 32'h1;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	AST_V_GLIDE: assert property (
		!rd && !v.source && !$past(v.source) && v.vco_khz > $past(v.vco_khz) |-> v.vco_khz - $past(v.vco_khz) <= GLIDE_STEP_KHZ)
		else $error("video glide step too large");
	AST_M_GLIDE: assert property (
		!rd && !m.source && !$past(m.source) && m.vco_khz < $past(m.vco_khz) |-> $past(m.vco_khz) - m.vco_khz <= GLIDE_STEP_KHZ)
		else $error("memory glide step too large");
	AST_DIV_RISE: assert property (
		!rd && !v.source && !$past(v.source) && v.post_div > $past(v.post_div) |-> $rose(VIDEO_BUSY))
		else $error("divider rise not at start");
	AST_DIV_FALL: assert property (
		!rd && !v.source && !$past(v.source) && v.post_div < $past(v.post_div) |-> ##[0:1] !VIDEO_BUSY)
		else $error("divider fall not at end");
	AST_V_HOLD: assert property (
		$rose(VIDEO_BUSY) && REF_MUX_TRANSITION |-> !v.source [*8] ##[1:3] v.source) else $error("video hold wrong");
	AST_M_HOLD: assert property (
		$rose(MEMORY_BUSY) && REF_MUX_TRANSITION |-> !m.source [*8] ##[1:3] m.source) else $error("memory hold wrong");
	AST_V_RETURN: assert property (
		!rd && $fell(v.source) |-> (vsub + 32'h1 >= TIMEOUT_CYCLES && vsub <= TIMEOUT_CYCLES + 1) ##[0:1] !VIDEO_BUSY)
		else $error("video settle time wrong");
	AST_RELOCK: assert property (
		!rd && $rose(PLL_LOCKED) |-> lowc + 32'h1 >= RELOCK_CYCLES && lowc <= RELOCK_CYCLES + 1) else $error("relock time wrong");
	AST_LOCK_DROP: assert property (
		!rd && $changed(ANALOG_SUPPLY_TRIP) |-> ##[1:4] !PLL_LOCKED) else $error("lock not dropped");
	AST_MEM_FIRST: assert property (
		RESET_OPTION && $rose(VIDEO_BUSY) |-> !MEMORY_BUSY) else $error("video started before memory done");
	cover property ($rose(v.source));
	cover property ($rose(m.source) && RESET_OPTION);
	cover property ($fell(PLL_LOCKED));
endmodule : dpft_transition_properties

// *** tb/tb.sv ***
module tb
	import dpft_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TO = 20;
	localparam int RL = 30;
	logic                   clk   = 1'b0;
	logic                   rst   = 1'b1;
	logic                   mux   = 1'b0;
	logic                   ropt  = 1'b0;
	logic                   split = 1'b0;
	logic                   trip  = 1'b0;
	logic                   pclr  = 1'b0;
	logic [1:0]             sel   = 2'h0;
	dpft_write_type         wr    = '0;
	dpft_clock_type         vout, mout, ev, em;
	logic                   vbusy, mbusy, locked;
	logic [1:0][FREQ_W-1:0] pk;
	dpft_setting_type       vb [4];
	dpft_setting_type       mb [2];
	int                     seed = 73611;
	int                     miscompares = 0;
	int                     n_tests = 0;
	always #2 clk = ~clk;
	dpft_transition #(.TIMEOUT_CYCLES(TO), .RELOCK_CYCLES(RL)) dpft_transition_inst (
		.CLK(clk), .SYS_RST(rst), .REF_MUX_TRANSITION(mux), .RESET_OPTION(ropt), .SPLIT_SUPPLY(split),
		.REGISTER_SELECT_LO(sel[0]), .REGISTER_SELECT_HI(sel[1]), .ANALOG_SUPPLY_TRIP(trip), .WRITE(wr),
		.VIDEO_CLOCK_OUT(vout), .MEMORY_CLOCK_OUT(mout), .VIDEO_BUSY(vbusy), .MEMORY_BUSY(mbusy), .PLL_LOCKED(locked));
	dpft_consumer dpft_consumer_inst (.clk(clk), .clear(pclr), .clock_in({mout, vout}), .peak(pk));
	task automatic cmp_clk(input string name, input dpft_clock_type exp, input dpft_clock_type got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : cmp_clk
	task automatic cmp_bit(input string name, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %b seen %b", name, exp, got);
		end
	endtask : cmp_bit
	function automatic dpft_clock_type fix(input dpft_setting_type s, input logic mem);
		logic [FREQ_W-1:0] lo;
		logic [FREQ_W-1:0] hi;
		lo = mem ? MEMORY_MIN_KHZ : VIDEO_MIN_KHZ;
		hi = mem ? (split ? MEMORY_MAX_LOW_KHZ : MEMORY_MAX_FULL_KHZ) : (split ? VIDEO_MAX_LOW_KHZ : VIDEO_MAX_FULL_KHZ);
		s.vco_khz = (s.vco_khz < lo) ? lo : (s.vco_khz > hi) ? hi : s.vco_khz;
		return '{source: SRC_VCO, post_div: s.post_div, vco_khz: s.vco_khz};
	endfunction : fix
	task automatic put(input logic mem, input logic [1:0] idx, input dpft_setting_type d);
		@(posedge clk);
		wr <= '{valid: 1'b1, to_memory: mem, index: idx, data: d};
		@(posedge clk);
		wr.valid <= 1'b0;
		if (mem) mb[idx[0]] = d;
		else vb[idx] = d;
	endtask : put
	task automatic settle();
		int idle;
		idle = 0;
		repeat (8) @(negedge clk);
		for (int i = 0; i < 20000 && idle < 6; i++) begin
			@(negedge clk);
			idle = (vbusy === 1'b0 && mbusy === 1'b0) ? idle + 1 : 0;
		end
		cmp_bit("settled", 1'b1, idle == 6);
	endtask : settle
	task automatic run_op(input logic mem);
		dpft_setting_type  d;
		dpft_clock_type    e;
		logic [FREQ_W-1:0] top;
		@(posedge clk);
		pclr <= 1'b1;
		d.post_div = 2'($unsigned($random(seed)) % 3);
		d.vco_khz  = 18'(60000 + $unsigned($random(seed)) % 50000);
		e = fix(d, mem);
		top = mem ? em.vco_khz >> em.post_div : ev.vco_khz >> ev.post_div;
		if ((e.vco_khz >> e.post_div) > top) top = e.vco_khz >> e.post_div;
		@(posedge clk);
		pclr <= 1'b0;
		put(mem, mem ? {1'b0, ropt && sel == 2'h3} : sel, d);
		if (mem) em = e;
		else ev = e;
		settle();
		cmp_clk(mem ? "memory" : "video", e, mem ? mout : vout);
		cmp_bit("peak", 1'b1, pk[mem] <= top);
	endtask : run_op
	task automatic pick(input logic [1:0] code);
		@(posedge clk);
		sel <= code;
		ev = fix(vb[code], 1'b0);
		if (ropt) em = fix(mb[code == 2'h3], 1'b1);
		settle();
		cmp_clk("video", ev, vout);
		cmp_clk("memory", em, mout);
	endtask : pick
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		finish_test();
	end
	initial begin
		vb = '{default: VIDEO_RESET_SETTING};
		mb = '{default: MEMORY_RESET_SETTING};
		ev = fix(VIDEO_RESET_SETTING, 1'b0);
		em = fix(MEMORY_RESET_SETTING, 1'b1);
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(negedge clk);
		cmp_clk("video", ev, vout);
		cmp_clk("memory", em, mout);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			split <= i[1];
			run_op(i[0]);
		end
		@(posedge clk);
		split <= 1'b0;
		mux <= 1'b1;
		run_op(1'b0);
		run_op(1'b1);
		for (int i = 1; i < 4; i++) begin
			put(1'b0, 2'(i), '{post_div: 2'(i - 1), vco_khz: 18'(60000 + 9000 * i)});
		end
		put(1'b1, 2'h1, '{post_div: 2'h1, vco_khz: 18'h11170});
		repeat (3) @(negedge clk);
		cmp_bit("busy", 1'b0, vbusy | mbusy);
		pick(2'h2);
		pick(2'h1);
		@(posedge clk);
		ropt <= 1'b1;
		pick(2'h3);
		pick(2'h0);
		@(posedge clk);
		trip <= 1'b1;
		repeat (6) @(negedge clk);
		cmp_bit("locked", 1'b0, locked);
		repeat (RL) @(negedge clk);
		cmp_bit("locked", 1'b1, locked);
		finish_test();
	end
endmodule : tb
bind dpft_transition dpft_transition_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .RELOCK_CYCLES(RELOCK_CYCLES))
	dpft_transition_properties_inst (.CLK(CLK), .SYS_RST(SYS_RST), .REF_MUX_TRANSITION(REF_MUX_TRANSITION),
	.RESET_OPTION(RESET_OPTION), .ANALOG_SUPPLY_TRIP(ANALOG_SUPPLY_TRIP), .VIDEO_CLOCK_OUT(VIDEO_CLOCK_OUT),
	.MEMORY_CLOCK_OUT(MEMORY_CLOCK_OUT), .VIDEO_BUSY(VIDEO_BUSY), .MEMORY_BUSY(MEMORY_BUSY), .PLL_LOCKED(PLL_LOCKED));
